// ===== rtl/ogc_map.svh
/*
  Register map, field positions and reset values of the output gain
  control bank. Assumes a 32-bit Wishbone slave that decodes word
  addresses: byte address = 4 * register index.
*/
// Functional notes
// - Each headphone stage takes a 6-bit level in bits 5:0, -57 dB to +6 dB in 1 dB steps.
// - Both headphone levels reset to 101101.
// - Writing one to bit 8 of either headphone register applies both headphone levels together.
// - Headphone bit 7 picks immediate (0) or zero-cross (1) gain changes, reset 0.
// - Headphone bit 6 is an active-low mute, reset 1 (audio passes).
// - The four line output halves mute with bits 6, 5, 2 and 1 (1 mutes), all reset 1.
// - Line bits 4 and 0 set 0 dB or -6 dB for a whole differential pair.
// - The earpiece mutes with bit 5 (1 mutes), reset 1.
// - The earpiece gain is 0 dB or -6 dB by bit 4, reset 0.
// - Each mixer-output stage takes a 6-bit level, -57 dB to +6 dB, reset 111001.
// - Writing one to bit 8 of either mixer-output register applies both mixer levels together.
// - Mixer-output bit 7 picks zero-cross (1) or immediate (0) changes, reset 0.
// - Mixer-output bit 6 is an active-low mute, reset 1.
// - Speaker mixer bits 5 to 2 each add -3 dB on one input when set.
// - The 2-bit speaker mixer level codes 0, -6, -12 dB and mute, reset 11.
`ifndef OGC_MAP_SVH
`define OGC_MAP_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define OGC_IDX_HP_L 6'h1C
`define OGC_IDX_HP_R 6'h1D
`define OGC_IDX_LINE 6'h1E
`define OGC_IDX_EAR 6'h1F
`define OGC_IDX_MIX_L 6'h20
`define OGC_IDX_MIX_R 6'h21
`define OGC_IDX_SPK 6'h22
`define OGC_IDX_STATUS 6'h3F

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define OGC_ADR_MSB 7
`define OGC_ADR_LSB 2
`define OGC_B_COMMIT 8
`define OGC_B_ZC 7
`define OGC_B_UNMUTE 6
`define OGC_B_LINE_A_NEG 6
`define OGC_B_LINE_A_POS 5
`define OGC_B_LINE_A_CUT 4
`define OGC_B_LINE_B_NEG 2
`define OGC_B_LINE_B_POS 1
`define OGC_B_LINE_B_CUT 0
`define OGC_B_EAR_SILENCE 5
`define OGC_B_EAR_CUT 4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define OGC_HP_LEVEL_RST 6'h2D
`define OGC_MIX_LEVEL_RST 6'h39
`define OGC_ZC_RST 1'h0
`define OGC_UNMUTE_RST 1'h1
`define OGC_LINE_RST 6'h36
`define OGC_EAR_SILENCE_RST 1'h1
`define OGC_EAR_CUT_RST 1'h0
`define OGC_SPK_RST 6'h03

`endif

// ===== rtl/ogc_pkg.sv
/*
  Types shared by the output gain control bank and its users.
  Assumes nothing of its surroundings.
*/
package ogc_pkg;

  // One volume stage, laid out as register bits 7:0
  typedef struct packed {
    logic zero_cross;
    logic unmute;
    logic [5:0] level;
  } ogc_stage_s;

  // Both differential line outputs
  typedef struct packed {
    logic a_neg_silence;
    logic a_pos_silence;
    logic a_cut;
    logic b_neg_silence;
    logic b_pos_silence;
    logic b_cut;
  } ogc_line_s;

  // Left speaker mixer trims, laid out as register bits 5:0
  typedef struct packed {
    logic left_bypass_fine_cut;
    logic left_input_fine_cut;
    logic left_mixer_fine_cut;
    logic left_converter_fine_cut;
    logic [1:0] left_speaker_sum_level;
  } ogc_spk_s;

endpackage

// ===== rtl/ogc_regs.sv
/*
  Output gain control register bank: headphone and mixer-output
  volume stages with paired commit and zero-cross timing, line
  output, earpiece and left speaker mixer controls.
  Assumes a classic Wishbone master on i_clk and zero-cross level
  inputs from the analogue side, asynchronous to i_clk.
*/
`timescale 1ns/10ps
`include "ogc_map.svh"

module ogc_regs
  import ogc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Zero-cross levels: 0 phones L, 1 phones R, 2 mixer L, 3 mixer R
  input wire logic [3:0] i_zero_cross,
  // Applied volume stages, same order
  output ogc_stage_s [3:0] o_gain,
  // Static output controls
  output ogc_line_s o_line,
  output logic o_earpiece_silence,
  output logic o_earpiece_cut,
  output ogc_spk_s o_spk
);

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------

  logic take;
  logic wr;
  logic [5:0] idx;
  logic [1:0] commit;
  logic [31:0] rd_nxt;

  // A request is taken once, in the cycle before ack
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr = take && i_wb_we;
  assign idx = i_wb_adr[`OGC_ADR_MSB:`OGC_ADR_LSB];

  // Commit strobes: pair 0 phones, pair 1 mixer outputs
  always_comb
  begin
    commit[0] = wr && i_wb_sel[1] && i_wb_dat[`OGC_B_COMMIT]
      && (idx == `OGC_IDX_HP_L || idx == `OGC_IDX_HP_R);
    commit[1] = wr && i_wb_sel[1] && i_wb_dat[`OGC_B_COMMIT]
      && (idx == `OGC_IDX_MIX_L || idx == `OGC_IDX_MIX_R);
  end

  // Map a stage number to its register index
  function automatic logic [5:0] stage_idx(input int unsigned n);
    logic [5:0] r;
    r = `OGC_IDX_HP_L;
    case (n)
      1: r = `OGC_IDX_HP_R;
      2: r = `OGC_IDX_MIX_L;
      3: r = `OGC_IDX_MIX_R;
      default: r = `OGC_IDX_HP_L;
    endcase
    return r;
  endfunction

  // -----------------------------------------------------------------
  // Zero-cross synchronisers
  // -----------------------------------------------------------------

  logic [3:0] zc_meta_r;
  logic [3:0] zc_sync_r;
  logic [3:0] zc_last_r;
  logic [2:0] zc_ready_r;
  logic [3:0] zc_edge;

  // Two flops before use, a third for edge detection
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      zc_meta_r <= 4'h0;
      zc_sync_r <= 4'h0;
      zc_last_r <= 4'h0;
      zc_ready_r <= 3'h0;
    end
    else
    begin
      zc_meta_r <= i_zero_cross;
      zc_sync_r <= zc_meta_r;
      zc_last_r <= zc_sync_r;
      zc_ready_r <= {zc_ready_r[1:0], 1'b1};
    end
  end

  // Either polarity change marks a crossing; masked until the edge flop
  // holds the pin, so a pin resting high gives no false crossing
  assign zc_edge = (zc_sync_r ^ zc_last_r) & {4{zc_ready_r[2]}};

  // -----------------------------------------------------------------
  // Volume stages
  // -----------------------------------------------------------------

  ogc_stage_s [3:0] pend_r;
  logic [3:0] armed_r;

  for (genvar g = 0; g < 4; g++)
  begin : g_stage
    localparam logic [5:0] LEVEL_RST =
      (g < 2) ? `OGC_HP_LEVEL_RST : `OGC_MIX_LEVEL_RST;
    logic hit;
    logic apply;

    assign hit = wr && i_wb_sel[0] && idx == stage_idx(g);
    // Wait for a crossing only when zero-cross timing is on
    assign apply = armed_r[g]
      && (!pend_r[g].zero_cross || zc_edge[g]);

    // Pending level, mode and mute as software wrote them
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        pend_r[g].zero_cross <= `OGC_ZC_RST;
        pend_r[g].unmute <= `OGC_UNMUTE_RST;
        pend_r[g].level <= LEVEL_RST;
      end
      else if (hit)
      begin
        pend_r[g] <= i_wb_dat[7:0];
      end
    end

    // Commit arms the stage; a new commit wins over the apply
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        armed_r[g] <= 1'b0;
      end
      else if (commit[g / 2])
      begin
        armed_r[g] <= 1'b1;
      end
      else if (apply)
      begin
        armed_r[g] <= 1'b0;
      end
    end

    // Applied stage: level on apply, mute and mode at once
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
      begin
        o_gain[g].zero_cross <= `OGC_ZC_RST;
        o_gain[g].unmute <= `OGC_UNMUTE_RST;
        o_gain[g].level <= LEVEL_RST;
      end
      else
      begin
        o_gain[g].zero_cross <= pend_r[g].zero_cross;
        o_gain[g].unmute <= pend_r[g].unmute;
        if (apply)
        begin
          o_gain[g].level <= pend_r[g].level;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Line outputs
  // -----------------------------------------------------------------

  // Four mutes and two pair gains, each on its own bit
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_line <= `OGC_LINE_RST;
    end
    else if (wr && i_wb_sel[0] && idx == `OGC_IDX_LINE)
    begin
      o_line.a_neg_silence <= i_wb_dat[`OGC_B_LINE_A_NEG];
      o_line.a_pos_silence <= i_wb_dat[`OGC_B_LINE_A_POS];
      o_line.a_cut <= i_wb_dat[`OGC_B_LINE_A_CUT];
      o_line.b_neg_silence <= i_wb_dat[`OGC_B_LINE_B_NEG];
      o_line.b_pos_silence <= i_wb_dat[`OGC_B_LINE_B_POS];
      o_line.b_cut <= i_wb_dat[`OGC_B_LINE_B_CUT];
    end
  end

  // -----------------------------------------------------------------
  // Earpiece and speaker mixer
  // -----------------------------------------------------------------

  // Earpiece starts silent at 0 dB
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_earpiece_silence <= `OGC_EAR_SILENCE_RST;
      o_earpiece_cut <= `OGC_EAR_CUT_RST;
    end
    else if (wr && i_wb_sel[0] && idx == `OGC_IDX_EAR)
    begin
      o_earpiece_silence <= i_wb_dat[`OGC_B_EAR_SILENCE];
      o_earpiece_cut <= i_wb_dat[`OGC_B_EAR_CUT];
    end
  end

  // Four fine trims and the summed level, straight from bits 5:0
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_spk <= `OGC_SPK_RST;
    end
    else if (wr && i_wb_sel[0] && idx == `OGC_IDX_SPK)
    begin
      o_spk <= i_wb_dat[5:0];
    end
  end

  // -----------------------------------------------------------------
  // Read back and acknowledge
  // -----------------------------------------------------------------

  // Commit bits read as zero; unmapped words read as zero
  always_comb
  begin
    rd_nxt = 32'h0;
    case (idx)
      `OGC_IDX_HP_L: rd_nxt[7:0] = pend_r[0];
      `OGC_IDX_HP_R: rd_nxt[7:0] = pend_r[1];
      `OGC_IDX_MIX_L: rd_nxt[7:0] = pend_r[2];
      `OGC_IDX_MIX_R: rd_nxt[7:0] = pend_r[3];
      `OGC_IDX_LINE:
      begin
        rd_nxt[`OGC_B_LINE_A_NEG] = o_line.a_neg_silence;
        rd_nxt[`OGC_B_LINE_A_POS] = o_line.a_pos_silence;
        rd_nxt[`OGC_B_LINE_A_CUT] = o_line.a_cut;
        rd_nxt[`OGC_B_LINE_B_NEG] = o_line.b_neg_silence;
        rd_nxt[`OGC_B_LINE_B_POS] = o_line.b_pos_silence;
        rd_nxt[`OGC_B_LINE_B_CUT] = o_line.b_cut;
      end
      `OGC_IDX_EAR:
      begin
        rd_nxt[`OGC_B_EAR_SILENCE] = o_earpiece_silence;
        rd_nxt[`OGC_B_EAR_CUT] = o_earpiece_cut;
      end
      `OGC_IDX_SPK: rd_nxt[5:0] = o_spk;
      `OGC_IDX_STATUS: rd_nxt[3:0] = armed_r;
      default: rd_nxt = 32'h0;
    endcase
  end

  // One-cycle ack; read data held until the next read request
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end
    else
    begin
      o_wb_ack <= take;
      if (take && !i_wb_we)
      begin
        o_wb_dat <= rd_nxt;
      end
    end
  end

endmodule

// ===== tb/ogc_regs_sva.sv
/*
  Checker for the output gain control bank, bound to ogc_regs.
  Assumes it sees the bank's ports only, in one clock domain.
*/
`timescale 1ns/10ps

module ogc_regs_sva
  import ogc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Wishbone side
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Gain side
  input wire logic [3:0] i_zero_cross,
  input wire ogc_stage_s [3:0] o_gain,
  input wire ogc_line_s o_line,
  input wire logic o_earpiece_silence,
  input wire logic o_earpiece_cut,
  input wire ogc_spk_s o_spk
);
  // Accepted request and accepted low-byte write
  logic take;
  logic wr;
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = take & i_wb_we & i_wb_sel[0];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_ack_pulse;
    take |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack is not one pulse after a request");

  property p_ack_cause;
    $rose(o_wb_ack) |-> $past(i_wb_cyc & i_wb_stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");

  property p_reset_vals;
    $rose(i_reset_n) |-> o_gain == 32'h7979_6D6D && o_line == 6'h36
      && o_spk == 6'h03 && o_earpiece_silence && !o_earpiece_cut;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs off their reset values");

  property p_line_write;
    wr && i_wb_adr == 8'h78
      |=> o_line == {$past(i_wb_dat[6:4]), $past(i_wb_dat[2:0])};
  endproperty
  a_line_write: assert property (p_line_write)
    else $error("line controls do not follow the write");

  property p_ear_write;
    wr && i_wb_adr == 8'h7C
      |=> {o_earpiece_silence, o_earpiece_cut} == $past(i_wb_dat[5:4]);
  endproperty
  a_ear_write: assert property (p_ear_write)
    else $error("earpiece controls do not follow the write");

  property p_spk_write;
    wr && i_wb_adr == 8'h88 |=> o_spk == $past(i_wb_dat[5:0]);
  endproperty
  a_spk_write: assert property (p_spk_write)
    else $error("speaker mixer trims do not follow the write");

  property p_commit_phones;
    wr && i_wb_adr == 8'h70 && i_wb_sel[1] && i_wb_dat[8:7] == 2'h2
      |-> ##2 o_gain[0].level == $past(i_wb_dat[5:0], 2);
  endproperty
  a_commit_phones: assert property (p_commit_phones)
    else $error("phones level not applied by commit");

  property p_commit_mixer;
    wr && i_wb_adr == 8'h80 && i_wb_sel[1] && i_wb_dat[8:7] == 2'h2
      |-> ##2 o_gain[2].level == $past(i_wb_dat[5:0], 2);
  endproperty
  a_commit_mixer: assert property (p_commit_mixer)
    else $error("mixer level not applied by commit");
endmodule

bind ogc_regs ogc_regs_sva u_ogc_regs_sva (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_zero_cross(i_zero_cross), .o_gain(o_gain),
  .o_line(o_line), .o_earpiece_silence(o_earpiece_silence),
  .o_earpiece_cut(o_earpiece_cut), .o_spk(o_spk)
);

// ===== tb/ogc_regs_test.sv
/*
  Self-checking bench for the output gain control bank.
  Assumes the bank, its package and its checker are compiled first.
*/
`timescale 1ns/10ps

module ogc_regs_test
  import ogc_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] zc = 4'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  ogc_stage_s [3:0] gain;
  ogc_line_s line;
  logic ear_s;
  logic ear_c;
  ogc_spk_s spk;
  int err_count = 0;
  int checks_done = 0;
  logic [7:0] ra [7] = '{8'h70, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h84, 8'h88};
  logic [31:0] rr [7] = '{32'h6D, 32'h6D, 32'h66, 32'h20, 32'h79, 32'h79,
                          32'h03};
  logic [7:0] sa [3] = '{8'h78, 8'h7C, 8'h88};
  logic [31:0] sm [3] = '{32'h77, 32'h30, 32'h3F};
  logic [7:0] pb [2] = '{8'h70, 8'h80};
  logic [5:0] pl [2] = '{6'h2D, 6'h39};

  ogc_regs u_ogc_regs (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_dat(q), .o_wb_ack(ack), .i_zero_cross(zc), .o_gain(gain),
    .o_line(line), .o_earpiece_silence(ear_s), .o_earpiece_cut(ear_c),
    .o_spk(spk)
  );

  // Free-running 250 MHz clock
  always #2 i_clk = ~i_clk;

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (ack !== 1'b1);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(n), 32'h2, "ack delay");
  endtask

  // Read-back value of a static register
  function automatic logic [31:0] rb(int k, logic [31:0] d);
    return d & sm[k];
  endfunction

  // Output value of a static register after a low-byte write
  function automatic logic [31:0] ov(int k, logic [31:0] d);
    if (k == 0)
      return {26'h0, d[6:4], d[2:0]};
    else if (k == 1)
      return {30'h0, d[5:4]};
    return {26'h0, d[5:0]};
  endfunction

  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #40000;
    err_count++;
    end_sim();
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    int k;
    logic [31:0] d;
    logic [5:0] a;
    logic [5:0] c;
    logic [31:0] got;
    void'($urandom(57123));
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (ra[i])
    begin
      wb(1'b0, ra[i], 32'h0, 4'hF);
      chk(rdat, rr[i], "reset value");
    end
    wb(1'b1, 8'h40, 32'h1FF, 4'hF);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    chk(rdat, 32'h0, "unmapped");
    repeat (24)
    begin
      k = $urandom_range(2);
      d = $urandom;
      wb(1'b1, sa[k], d, 4'h1);
      got = (k == 0) ? {26'h0, line} :
        (k == 1) ? {30'h0, ear_s, ear_c} : {26'h0, spk};
      chk(got, ov(k, d), "static out");
      wb(1'b0, sa[k], 32'h0, 4'hF);
      chk(rdat, rb(k, d), "static reg");
    end
    foreach (pb[p])
    begin
      a = 6'($urandom);
      c = a ^ 6'h15;
      wb(1'b1, pb[p], {26'h0, a}, 4'h1);
      wb(1'b1, pb[p] + 8'h04, {26'h0, ~a} | 32'h40, 4'h1);
      repeat (4) @(posedge i_clk);
      chk(32'(gain[2 * p].unmute), 32'h0, "mute");
      chk(32'(gain[2 * p].level), 32'(pl[p]), "pending");
      wb(1'b1, pb[p], 32'h100 | a, 4'h3);
      repeat (3) @(posedge i_clk);
      chk(32'(gain[2 * p].level), 32'(a), "commit");
      chk(32'(gain[2 * p + 1].level), {26'h0, ~a}, "pair");
      wb(1'b1, pb[p], 32'hC0 | a, 4'h1);
      wb(1'b1, pb[p], 32'h1C0 | c, 4'h3);
      repeat (6) @(posedge i_clk);
      chk(32'(gain[2 * p].level), 32'(a), "wait crossing");
      wb(1'b0, 8'hFC, 32'h0, 4'hF);
      chk(rdat, 32'h1 << (2 * p), "armed");
      zc[2 * p] <= ~zc[2 * p];
      repeat (8) @(posedge i_clk);
      chk(32'(gain[2 * p].level), 32'(c), "crossing");
      wb(1'b1, pb[p], 32'h40 | c, 4'h1);
    end
    end_sim();
  end
endmodule
